//--- hdl/adcsq_defs.svh
// Constants for the converter sequencer control block.
// Assumes inclusion by bare name from every file that needs them.
`ifndef ADCSQ_DEFS_SVH
`define ADCSQ_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ADCSQ_OFS_CONTROL     8'h1F
`define ADCSQ_OFS_PIN_CONFIG  8'h9F
`define ADCSQ_OFS_RESULT      8'h1E
`define ADCSQ_OFS_IRQ_FLAGS   8'h0C
`define ADCSQ_OFS_IRQ_ENABLES 8'h8C
`define ADCSQ_OFS_PORT        8'h05
`define ADCSQ_OFS_DIRECTION   8'h85

// ****************************************************************
// Field positions
// ****************************************************************
`define ADCSQ_BIT_ENABLE      0
`define ADCSQ_BIT_GO          2
`define ADCSQ_BIT_CHAN_LO     3
`define ADCSQ_BIT_CHAN_HI     4
`define ADCSQ_BIT_CLK_LO      6
`define ADCSQ_BIT_CLK_HI      7
`define ADCSQ_BIT_DONE_FLAG   6
`define ADCSQ_BIT_IRQ_ENABLE  6
`define ADCSQ_CONTROL_MASK    8'hDD

// ****************************************************************
// Reset values
// ****************************************************************
`define ADCSQ_RST_CONTROL     8'h00
`define ADCSQ_RST_PIN_CONFIG  8'h00
`define ADCSQ_RST_RESULT      8'h00
`define ADCSQ_RST_DIRECTION   8'h3F

// ****************************************************************
// Timing
// ****************************************************************
`define ADCSQ_CLK_HZ          20000000
`define ADCSQ_RC_PERIOD_NS    4000
`define ADCSQ_MCLK_PERIOD_NS  50
`define ADCSQ_RC_HALF_CYC     ((`ADCSQ_RC_PERIOD_NS / `ADCSQ_MCLK_PERIOD_NS) / 2)
`define ADCSQ_DIV2_HALF       1
`define ADCSQ_DIV8_HALF       4
`define ADCSQ_DIV32_HALF      16
`define ADCSQ_CONV_HALVES     19
`define ADCSQ_HOLDOFF_HALVES  4
`define ADCSQ_RESULT_BITS     8

`endif

//--- hdl/adcsq_pkg.sv
// Types for the converter sequencer control block.
// Assumes adcsq_defs.svh supplies the numbers.
package adcsq_pkg;
    typedef enum logic [1:0] {
        ADCSQ_CLK_DIV2,
        ADCSQ_CLK_DIV8,
        ADCSQ_CLK_DIV32,
        ADCSQ_CLK_RC
    } adcsq_clk_sel_t;

    typedef enum logic [1:0] {
        ADCSQ_IDLE,
        ADCSQ_CONVERT,
        ADCSQ_HOLDOFF
    } adcsq_state_t;
endpackage

//--- hdl/adcsq_tad_gen.sv
// Conversion bit period generator: emits one pulse per half period.
// Assumes mclk is the core clock; the RC source is modelled by mclk count.
`timescale 1ns/10ps
`include "adcsq_defs.svh"

module adcsq_tad_gen (
    input  wire logic                   mclk,
    input  wire logic                   reset_n,
    input  wire logic                   run,
    input  wire adcsq_pkg::adcsq_clk_sel_t sel,
    output logic                        half_tick
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic       tick_q;
    logic       tick_d;
    logic [7:0] limit;

    // Clock select decode: Fosc/2, /8, /32, or internal RC
    always_comb begin
        case (sel)
            adcsq_pkg::ADCSQ_CLK_DIV2:  limit = 8'(`ADCSQ_DIV2_HALF);
            adcsq_pkg::ADCSQ_CLK_DIV8:  limit = 8'(`ADCSQ_DIV8_HALF);
            adcsq_pkg::ADCSQ_CLK_DIV32: limit = 8'(`ADCSQ_DIV32_HALF);
            default:                    limit = 8'(`ADCSQ_RC_HALF_CYC);
        endcase
    end

    always_comb begin
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (!run) begin
            cnt_d = 8'h00;
        end else if (cnt_q + 8'h01 >= limit) begin
            cnt_d  = 8'h00;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 8'h01;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q  <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign half_tick = tick_q;
endmodule

//--- hdl/adcsq_ctrl.sv
// Sequencer control for a four channel 8-bit successive approximation converter.
// Assumes a one-clock register port master and a comparator from the analog side.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
`include "adcsq_defs.svh"

module adcsq_ctrl (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       sleep_mode,
    input  wire logic       comp_in,
    input  wire logic [3:0] pin_in,
    output logic      [1:0] chan_sel,
    output logic            ref_is_pin,
    output logic            analog_power,
    output logic            sample_connect,
    output logic      [7:0] dac_code,
    output logic      [3:0] analog_mask,
    output logic            periph_irq
);
    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0] control_q, control_d;
    logic [7:0] pin_cfg_q, pin_cfg_d;
    logic [7:0] result_q, result_d;
    logic [7:0] sar_q, sar_d;
    logic [7:0] trial_q, trial_d;
    logic [4:0] halves_q, halves_d;
    logic       flag_q, flag_d;
    logic       irq_en_q, irq_en_d;
    logic [5:0] dir_q, dir_d;
    logic [7:0] rdata_q, rdata_d;
    logic       irq_q, irq_d;
    logic       connect_q, connect_d;
    logic [1:0] comp_s_q;
    logic [3:0] pin_s1_q, pin_s2_q;
    adcsq_pkg::adcsq_state_t state_q, state_d;
    logic       half_tick;
    logic [3:0] amask;

    // Config code 0 means every pin analog with supply reference
    function automatic logic [3:0] analog_pins(input logic [7:0] cfg);
        case (cfg[2:0])
            3'h0:    analog_pins = 4'hF;
            3'h1:    analog_pins = 4'hF;
            3'h2:    analog_pins = 4'h7;
            3'h3:    analog_pins = 4'h3;
            3'h4:    analog_pins = 4'h3;
            3'h5:    analog_pins = 4'h1;
            default: analog_pins = 4'h0;
        endcase
    endfunction

    function automatic logic ref_from_pin(input logic [7:0] cfg);
        ref_from_pin = (cfg[2:0] == 3'h1) || (cfg[2:0] == 3'h4);
    endfunction

    assign amask = analog_pins(pin_cfg_q);

    adcsq_tad_gen u_tad (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .run       (control_q[`ADCSQ_BIT_ENABLE] && state_q != adcsq_pkg::ADCSQ_IDLE),
        .sel       (adcsq_pkg::adcsq_clk_sel_t'(control_q[`ADCSQ_BIT_CLK_HI:`ADCSQ_BIT_CLK_LO])),
        .half_tick (half_tick)
    );

    // ****************************************************************
    // Sequencer and register port
    // ****************************************************************
    always_comb begin
        control_d = control_q;
        pin_cfg_d = pin_cfg_q;
        result_d  = result_q;
        sar_d     = sar_q;
        trial_d   = trial_q;
        halves_d  = halves_q;
        flag_d    = flag_q;
        irq_en_d  = irq_en_q;
        dir_d     = dir_q;
        state_d   = state_q;
        connect_d = connect_q;
        rdata_d   = 8'h00;

        if (reg_wr) begin
            case (reg_addr)
                `ADCSQ_OFS_CONTROL: begin
                    control_d = reg_wdata & `ADCSQ_CONTROL_MASK;
                    // Go only arms when already enabled, so writing enable and go together sets enable but leaves go clear
                    if (!control_q[`ADCSQ_BIT_ENABLE]) begin
                        control_d[`ADCSQ_BIT_GO] = 1'b0;
                    end
                end
                `ADCSQ_OFS_PIN_CONFIG:  pin_cfg_d = {5'h00, reg_wdata[2:0]};
                `ADCSQ_OFS_RESULT:      result_d  = reg_wdata;
                `ADCSQ_OFS_IRQ_FLAGS:   flag_d    = reg_wdata[`ADCSQ_BIT_DONE_FLAG];
                `ADCSQ_OFS_IRQ_ENABLES: irq_en_d  = reg_wdata[`ADCSQ_BIT_IRQ_ENABLE];
                `ADCSQ_OFS_DIRECTION:   dir_d     = reg_wdata[5:0];
                default: ;
            endcase
        end

        case (state_q)
            adcsq_pkg::ADCSQ_IDLE: begin
                connect_d = control_q[`ADCSQ_BIT_ENABLE];
                if (control_q[`ADCSQ_BIT_GO] && control_q[`ADCSQ_BIT_ENABLE]) begin
                    state_d   = adcsq_pkg::ADCSQ_CONVERT;
                    halves_d  = 5'h00;
                    sar_d     = 8'h00;
                    trial_d   = 8'h80;
                    connect_d = 1'b0;
                end
            end
            adcsq_pkg::ADCSQ_CONVERT: begin
                if (!control_q[`ADCSQ_BIT_GO] || !control_q[`ADCSQ_BIT_ENABLE]) begin
                    state_d  = adcsq_pkg::ADCSQ_HOLDOFF;
                    halves_d = 5'h00;
                end else if (half_tick) begin
                    halves_d = halves_q + 5'h01;
                    // Odd half periods after the first sample resolve one bit each
                    if (halves_q[0] && trial_q != 8'h00) begin
                        if (comp_s_q[1]) begin
                            sar_d = sar_q | trial_q;
                        end
                        trial_d = trial_q >> 1;
                    end
                    if (halves_q == 5'(`ADCSQ_CONV_HALVES - 1)) begin
                        // Result, go clear and flag land together
                        result_d  = sar_d;
                        control_d[`ADCSQ_BIT_GO] = 1'b0;
                        flag_d    = 1'b1;
                        state_d   = adcsq_pkg::ADCSQ_HOLDOFF;
                        halves_d  = 5'h00;
                    end
                end
            end
            adcsq_pkg::ADCSQ_HOLDOFF: begin
                // Go set during holdoff waits until holdoff ends, then starts from idle without reconnecting the holding capacitor
                if (!control_q[`ADCSQ_BIT_ENABLE]) begin
                    state_d = adcsq_pkg::ADCSQ_IDLE;
                end else if (half_tick) begin
                    halves_d = halves_q + 5'h01;
                    if (halves_q == 5'(`ADCSQ_HOLDOFF_HALVES - 1)) begin
                        state_d = adcsq_pkg::ADCSQ_IDLE;
                    end
                end
            end
            default: state_d = adcsq_pkg::ADCSQ_IDLE;
        endcase

        if (reg_rd) begin
            case (reg_addr)
                `ADCSQ_OFS_CONTROL:     rdata_d = control_q;
                `ADCSQ_OFS_PIN_CONFIG:  rdata_d = pin_cfg_q;
                `ADCSQ_OFS_RESULT:      rdata_d = result_q;
                `ADCSQ_OFS_IRQ_FLAGS:   rdata_d = {1'b0, flag_q, 6'h00};
                `ADCSQ_OFS_IRQ_ENABLES: rdata_d = {1'b0, irq_en_q, 6'h00};
                `ADCSQ_OFS_DIRECTION:   rdata_d = {2'b00, dir_q};
                `ADCSQ_OFS_PORT:        rdata_d = {4'h0, pin_s2_q & ~amask};
                default:                rdata_d = 8'h00;
            endcase
        end

        irq_d = flag_d && irq_en_d;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            control_q <= `ADCSQ_RST_CONTROL;
            pin_cfg_q <= `ADCSQ_RST_PIN_CONFIG;
            result_q  <= `ADCSQ_RST_RESULT;
            sar_q     <= 8'h00;
            trial_q   <= 8'h00;
            halves_q  <= 5'h00;
            flag_q    <= 1'b0;
            irq_en_q  <= 1'b0;
            dir_q     <= 6'(`ADCSQ_RST_DIRECTION);
            rdata_q   <= 8'h00;
            irq_q     <= 1'b0;
            connect_q <= 1'b0;
            state_q   <= adcsq_pkg::ADCSQ_IDLE;
        end else begin
            control_q <= control_d;
            pin_cfg_q <= pin_cfg_d;
            result_q  <= result_d;
            sar_q     <= sar_d;
            trial_q   <= trial_d;
            halves_q  <= halves_d;
            flag_q    <= flag_d;
            irq_en_q  <= irq_en_d;
            dir_q     <= dir_d;
            rdata_q   <= rdata_d;
            irq_q     <= irq_d;
            connect_q <= connect_d;
            state_q   <= state_d;
        end
    end

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    // Sleep does not gate anything here, so conversions run on through it
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            comp_s_q <= 2'b00;
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
        end else begin
            comp_s_q <= {comp_s_q[0], comp_in};
            pin_s1_q <= pin_in;
            pin_s2_q <= pin_s1_q;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    logic [1:0] chan_q;
    logic       ref_q, power_q;
    logic [7:0] dac_q;
    logic [3:0] amask_q;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            chan_q  <= 2'b00;
            ref_q   <= 1'b0;
            power_q <= 1'b0;
            dac_q   <= 8'h00;
            amask_q <= 4'hF;
        end else begin
            chan_q  <= control_q[`ADCSQ_BIT_CHAN_HI:`ADCSQ_BIT_CHAN_LO];
            ref_q   <= ref_from_pin(pin_cfg_q);
            power_q <= control_q[`ADCSQ_BIT_ENABLE];
            dac_q   <= sar_q | trial_q;
            amask_q <= amask;
        end
    end

    assign reg_rdata      = rdata_q;
    assign chan_sel       = chan_q;
    assign ref_is_pin     = ref_q;
    assign analog_power   = power_q;
    assign sample_connect = connect_q;
    assign dac_code       = dac_q;
    assign analog_mask    = amask_q;
    assign periph_irq     = irq_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_done_event: assert property (@(posedge mclk) disable iff (!reset_n)
        (state_q == adcsq_pkg::ADCSQ_CONVERT && state_d == adcsq_pkg::ADCSQ_HOLDOFF
         && control_q[`ADCSQ_BIT_GO] && control_q[`ADCSQ_BIT_ENABLE])
        |=> flag_q && !control_q[`ADCSQ_BIT_GO])
        else $error("completion did not set flag and clear go");
    chk_abort_keeps: assert property (@(posedge mclk) disable iff (!reset_n)
        (state_q == adcsq_pkg::ADCSQ_CONVERT && !control_q[`ADCSQ_BIT_GO] && !reg_wr)
        |=> $stable(result_q))
        else $error("abort changed result");
    chk_irq_follows: assert property (@(posedge mclk) disable iff (!reset_n)
        (flag_q && irq_en_q) |-> periph_irq)
        else $error("interrupt request missing");
    chk_reserved_zero: assert property (@(posedge mclk) disable iff (!reset_n)
        (control_q & ~`ADCSQ_CONTROL_MASK) == 8'h00)
        else $error("reserved control bits set");
    chk_go_needs_on: assert property (@(posedge mclk) disable iff (!reset_n)
        (reg_wr && reg_addr == `ADCSQ_OFS_CONTROL && !control_q[`ADCSQ_BIT_ENABLE])
        |=> !control_q[`ADCSQ_BIT_GO])
        else $error("go armed while converter off");
    chk_port_zero: assert property (@(posedge mclk) disable iff (!reset_n)
        (reg_rd && reg_addr == `ADCSQ_OFS_PORT) |=> (reg_rdata[3:0] & amask) == 4'h0)
        else $error("analog pin read non-zero");
    chk_holdoff_min: assert property (@(posedge mclk) disable iff (!reset_n)
        (state_q == adcsq_pkg::ADCSQ_HOLDOFF && state_d == adcsq_pkg::ADCSQ_IDLE
         && control_q[`ADCSQ_BIT_ENABLE]) |-> halves_q == 5'(`ADCSQ_HOLDOFF_HALVES - 1))
        else $error("holdoff ended early");
    chk_power_follow: assert property (@(posedge mclk) disable iff (!reset_n)
        ##1 analog_power == $past(control_q[`ADCSQ_BIT_ENABLE]))
        else $error("power output wrong");
    cov_convert_done: cover property (@(posedge mclk) disable iff (!reset_n)
        $rose(flag_q));
    cov_abort: cover property (@(posedge mclk) disable iff (!reset_n)
        state_q == adcsq_pkg::ADCSQ_CONVERT && !control_q[`ADCSQ_BIT_GO]);
    cov_sleep_conv: cover property (@(posedge mclk) disable iff (!reset_n)
        sleep_mode && $rose(flag_q));
endmodule

//--- tb/adcsq_analog_model.sv
// Behavioural analog side: per-channel levels, hold capacitor and comparator.
// Assumes levels are given in result units, so an ideal conversion returns the level.
`timescale 1ns/10ps

module adcsq_analog_model (
    input  wire logic            mclk,
    input  wire logic      [1:0] chan_sel,
    input  wire logic            analog_power,
    input  wire logic            sample_connect,
    input  wire logic      [7:0] dac_code,
    input  wire logic [3:0][7:0] chan_level,
    output logic                 comp_in
);
    logic [7:0] hold_q;
    logic       junk_q;

    // ****************************************************************
    // Hold capacitor tracks the channel only while connected
    // ****************************************************************
    always @(posedge mclk) begin
        if (sample_connect) begin
            hold_q <= chan_level[chan_sel];
        end
        junk_q <= ~junk_q;
    end

    initial begin
        junk_q = 1'b0;
        hold_q = 8'h00;
    end

    // Unpowered comparator gives garbage, so a design that samples it then is caught
    assign comp_in = analog_power ? (hold_q >= dac_code) : junk_q;
endmodule

//--- tb/tb.sv
// Self-checking bench for the converter sequencer control block.
// Assumes adcsq_defs.svh offsets and timing constants and the analog model.
`timescale 1ns/10ps
`include "adcsq_defs.svh"

module tb;
    logic            mclk, reset_n, reg_wr, reg_rd, sleep_mode, comp_in;
    logic      [7:0] reg_addr, reg_wdata, reg_rdata, dac_code, d, prev;
    logic      [3:0] pin_in, analog_mask;
    logic      [1:0] chan_sel;
    logic            ref_is_pin, analog_power, sample_connect, periph_irq;
    logic [3:0][7:0] chan_level;
    int              error_cnt, check_count, cyc;

    adcsq_ctrl u_adcsq_ctrl (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sleep_mode(sleep_mode), .comp_in(comp_in), .pin_in(pin_in), .chan_sel(chan_sel),
        .ref_is_pin(ref_is_pin), .analog_power(analog_power),
        .sample_connect(sample_connect), .dac_code(dac_code), .analog_mask(analog_mask),
        .periph_irq(periph_irq));

    adcsq_analog_model u_adcsq_analog_model (.mclk(mclk), .chan_sel(chan_sel),
        .analog_power(analog_power), .sample_connect(sample_connect), .dac_code(dac_code),
        .chan_level(chan_level), .comp_in(comp_in));

    always #25 mclk = ~mclk;

    // ****************************************************************
    // Bus tasks, checks and expectations
    // ****************************************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(what, exp, v);
    endtask

    function automatic logic [7:0] sar_expect(input logic [7:0] v);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            c[i] = 1'b1;
            if (v < c) c[i] = 1'b0;
        end
        return c;
    endfunction

    function automatic int half_of(input logic [1:0] s);
        case (s)
            2'b00:   return `ADCSQ_DIV2_HALF;
            2'b01:   return `ADCSQ_DIV8_HALF;
            2'b10:   return `ADCSQ_DIV32_HALF;
            default: return `ADCSQ_RC_HALF_CYC;
        endcase
    endfunction

    function automatic logic [3:0] mask_of(input logic [2:0] c);
        case (c)
            3'd0, 3'd1: return 4'hF;
            3'd2:       return 4'h7;
            3'd3, 3'd4: return 4'h3;
            3'd5:       return 4'h1;
            default:    return 4'h0;
        endcase
    endfunction

    // One full conversion, polled on the status bit
    task automatic convert(input logic [1:0] s, input logic [1:0] ch, input logic [7:0] lvl,
                           input logic ien);
        logic [7:0] ctl;
        int         h, t0;
        ctl = {s, 1'b0, ch, 3'b001};
        h   = half_of(s);
        chan_level[ch] <= lvl;
        wr(`ADCSQ_OFS_IRQ_ENABLES, {1'b0, ien, 6'h00});
        wr(`ADCSQ_OFS_CONTROL, ctl);
        repeat (20) @(posedge mclk);
        chk("connect idle", 8'h01, {7'h00, sample_connect});
        wr(`ADCSQ_OFS_CONTROL, ctl | 8'h04);
        t0 = cyc;
        for (int n = 0; n < 1000; n++) begin
            rd(`ADCSQ_OFS_CONTROL, d);
            if (d[2] !== 1'b1) break;
        end
        chk("connect holdoff", 8'h00, {7'h00, sample_connect});
        chk("control after", ctl, d);
        check_count++;
        if (cyc - t0 < 18 * h || cyc - t0 > 20 * h + 8) begin
            error_cnt++;
            $display("wrong value duration expected %0d seen %0d", 19 * h, cyc - t0);
        end
        rchk("result", `ADCSQ_OFS_RESULT, sar_expect(lvl));
        rchk("flag", `ADCSQ_OFS_IRQ_FLAGS, 8'h40);
        chk("irq", {7'h00, ien}, {7'h00, periph_irq});
        wr(`ADCSQ_OFS_IRQ_FLAGS, 8'h00);
        repeat (2) @(posedge mclk);
        chk("irq cleared", 8'h00, {7'h00, periph_irq});
        repeat (4 * h + 4) @(posedge mclk);
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        mclk = 1'b0; reset_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
        reg_wdata = 8'h00; sleep_mode = 1'b0; pin_in = 4'hF; chan_level = '0;
        error_cnt = 0; check_count = 0; cyc = 0;
        void'($urandom(32'h31369ef1));
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        rchk("control rst", `ADCSQ_OFS_CONTROL, 8'h00);
        rchk("config rst", `ADCSQ_OFS_PIN_CONFIG, 8'h00);
        rchk("result rst", `ADCSQ_OFS_RESULT, 8'h00);
        rchk("dir rst", `ADCSQ_OFS_DIRECTION, 8'h3F);
        rchk("port analog", `ADCSQ_OFS_PORT, 8'h00);
        rchk("unmapped", 8'h40, 8'h00);
        wr(`ADCSQ_OFS_CONTROL, 8'hFF);
        rchk("reserved", `ADCSQ_OFS_CONTROL, 8'hD9);
        chk("power on", 8'h01, {7'h00, analog_power});
        wr(`ADCSQ_OFS_CONTROL, 8'h00);
        wr(`ADCSQ_OFS_CONTROL, 8'h04);
        rchk("go disabled", `ADCSQ_OFS_CONTROL, 8'h00);
        chk("power off", 8'h00, {7'h00, analog_power});
        for (int c = 0; c < 8; c++) begin
            wr(`ADCSQ_OFS_PIN_CONFIG, 8'(c));
            repeat (2) @(posedge mclk);
            chk("mask", {4'h0, mask_of(3'(c))}, {4'h0, analog_mask});
            chk("ref", {7'h00, c == 1 || c == 4}, {7'h00, ref_is_pin});
        end
        wr(`ADCSQ_OFS_PIN_CONFIG, 8'h00);
        for (int ch = 0; ch < 4; ch++) begin
            wr(`ADCSQ_OFS_CONTROL, {3'b000, 2'(ch), 3'b001});
            repeat (2) @(posedge mclk);
            chk("chan", 8'(ch), {6'h00, chan_sel});
        end
        // Fast clocks break the minimum bit period, so only full scale has a defined result
        convert(2'b00, 2'd0, 8'hFF, 1'b1);
        convert(2'b01, 2'd3, 8'hFF, 1'b0);
        convert(2'b10, 2'd1, 8'h00, 1'b1);
        for (int s = 0; s < 4; s++) begin
            sleep_mode <= 1'b1;
            pin_in     <= 4'($urandom);
            convert(2'(2 + s % 2), 2'($urandom), 8'($urandom), 1'($urandom));
        end
        sleep_mode <= 1'b0;
        rd(`ADCSQ_OFS_RESULT, prev);
        chan_level[2] <= ~prev;
        wr(`ADCSQ_OFS_CONTROL, 8'h91);
        repeat (20) @(posedge mclk);
        wr(`ADCSQ_OFS_CONTROL, 8'h95);
        repeat (60) @(posedge mclk);
        wr(`ADCSQ_OFS_CONTROL, 8'h91);
        rchk("abort go", `ADCSQ_OFS_CONTROL, 8'h91);
        chk("abort connect", 8'h00, {7'h00, sample_connect});
        rchk("abort result", `ADCSQ_OFS_RESULT, prev);
        rchk("abort flag", `ADCSQ_OFS_IRQ_FLAGS, 8'h00);
        repeat (4 * `ADCSQ_DIV32_HALF + 6) @(posedge mclk);
        chk("reacquire", 8'h01, {7'h00, sample_connect});
        report_and_stop();
    end
endmodule
